// ---- hdl/dee_pkg.sv ----
package dee_pkg;

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_FLAG = 8'h0C;
    localparam logic [7:0] IDX_DATA = 8'h9A;
    localparam logic [7:0] IDX_ADDR = 8'h9B;
    localparam logic [7:0] IDX_CTRL = 8'h9C;
    localparam logic [7:0] IDX_UNLOCK = 8'h9D;

    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int CTRL_RD = 0;
    localparam int CTRL_WR = 1;
    localparam int CTRL_PERMIT = 2;
    localparam int CTRL_ERR = 3;
    localparam int FLAG_DONE = 7;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'hAA;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [1:0] STAGE_NONE = 2'h0;
    localparam logic [1:0] STAGE_FIRST = 2'h1;
    localparam logic [1:0] STAGE_ARMED = 2'h2;
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam int MEM_WORDS = 128;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int PWRT_MS = 72;
    localparam int PWRT_CYCLES_DEF = PWRT_MS * (CLK_HZ / 1000);
    localparam int WRITE_TIME_US = 4000;
    localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * (CLK_HZ / 1000000);
    localparam int CNT_W = 24;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef enum logic [0:0] {DEE_IDLE, DEE_BUSY} dee_wstate_t;

    typedef struct packed {
        logic [MEM_WORDS-1:0][7:0] mem;
        logic [7:0] dataReg;
        logic [6:0] addrReg;
        logic errFlag;
        logic permit;
        logic wrBit;
        logic rdBit;
        logic doneFlag;
        logic [1:0] unlock;
        dee_wstate_t wstate;
        logic [CNT_W-1:0] wcount;
        logic [CNT_W-1:0] pwrt;
        logic [6:0] wAddr;
        logic [7:0] wData;
        logic dphase;
        logic dwrite;
        logic dmapped;
        logic [7:0] didx;
        logic [7:0] rdata;
        logic [7:0] progData;
    } dee_state_t;

endpackage

// ---- hdl/dee_access_ctrl.sv ----
`timescale 1ns/1ps
// Overview of operation
// - 128-byte array, addresses 0 to 7F
// - byte write erases location before programming
// - self-timed programming duration, not software
// - protection blocks programmer path, not CPU
// - only address bits 6..0 select location
// - control bits 7..4 read zero
// - read/program start set-only, hardware clears
// - read loads data at once, one cycle
// - data register holds last read or bus-written value
// - write needs 55, AA, then start
// - sequence must take exact access count
// - program start needs write permit set
// - permit never hardware cleared except by reset, not disruptive
// - power-up clears write permit
// - power-up timer blocks program start, not register writes
// - completion clears start, sets done flag
// - non-power-on reset during write sets error flag
// - aborting reset clears address and data
// - unlock register stores nothing, reads zero
// - error 3, permit 2, start 1, read 0
module dee_access_ctrl
    import dee_pkg::*;
#(
    parameter int PWRT_CYCLES = PWRT_CYCLES_DEF,
    parameter int WRITE_CYCLES = WRITE_CYCLES_DEF
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic powerOnRst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic dataProtect,
    input wire logic progRead,
    input wire logic [6:0] progAddr,
    output logic [7:0] progData,
    output logic writeBusy,
    output logic programDoneFlag
);

    dee_state_t st;
    dee_state_t next_st;
    logic takeAccess;
    logic [7:0] readByte;

    // ------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------
    function automatic logic [7:0] regRead(input dee_state_t s,
                                           input logic [7:0] idx,
                                           input logic mapped);
        logic [7:0] v;
        v = 8'h00;
        if (mapped) begin
            case (idx)
                IDX_DATA: v = s.dataReg;
                IDX_ADDR: v = {1'b0, s.addrReg};
                IDX_CTRL: v = {4'h0, s.errFlag, s.permit, s.wrBit,
                               s.rdBit};
                IDX_FLAG: v = {s.doneFlag, 7'h00};
                default: v = 8'h00;
            endcase
        end
        return v;
    endfunction

    assign takeAccess = hsel && htrans[1] && hready;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.dphase = 1'b0;
        next_st.rdBit = 1'b0;
        if (st.pwrt != '0) begin
            next_st.pwrt = st.pwrt - 1'b1;
        end
        // Bus data phase
        if (st.dphase && st.dwrite && st.dmapped) begin
            next_st.unlock = STAGE_NONE;
            case (st.didx)
                IDX_DATA: next_st.dataReg = hwdata[7:0];
                IDX_ADDR: next_st.addrReg = hwdata[6:0];
                IDX_FLAG: begin
                    if (!hwdata[FLAG_DONE]) begin
                        next_st.doneFlag = 1'b0;
                    end
                end
                IDX_UNLOCK: begin
                    if (hwdata[7:0] == UNLOCK_FIRST) begin
                        next_st.unlock = STAGE_FIRST;
                    end else if (hwdata[7:0] == UNLOCK_SECOND &&
                                 st.unlock == STAGE_FIRST) begin
                        next_st.unlock = STAGE_ARMED;
                    end
                end
                IDX_CTRL: begin
                    next_st.errFlag = hwdata[CTRL_ERR];
                    next_st.permit = hwdata[CTRL_PERMIT];
                    if (hwdata[CTRL_RD]) begin
                        next_st.dataReg = st.mem[st.addrReg];
                        next_st.rdBit = 1'b1;
                    end
                    // Start only from the armed stage, with permit set
                    if (hwdata[CTRL_WR] && !st.wrBit && st.permit &&
                        st.unlock == STAGE_ARMED &&
                        st.pwrt == '0) begin
                        next_st.wrBit = 1'b1;
                        next_st.wstate = DEE_BUSY;
                        next_st.wcount = CNT_W'(WRITE_CYCLES);
                        next_st.wAddr = st.addrReg;
                        next_st.wData = st.dataReg;
                        next_st.mem[st.addrReg] = ERASED_BYTE;
                    end
                end
                default: begin
                end
            endcase
        end else if (st.dphase) begin
            next_st.unlock = STAGE_NONE;
        end
        // Self-timed engine; placed after the bus data phase so its set wins over a bus clear
        if (st.wstate == DEE_BUSY) begin
            if (st.wcount <= CNT_W'(1)) begin
                next_st.mem[st.wAddr] = st.wData;
                next_st.wrBit = 1'b0;
                next_st.doneFlag = 1'b1;
                next_st.errFlag = 1'b0;
                next_st.wstate = DEE_IDLE;
                next_st.wcount = '0;
            end else begin
                next_st.wcount = st.wcount - 1'b1;
            end
        end
        // Programmer path, denied under protection
        if (progRead) begin
            next_st.progData = dataProtect ? 8'h00 : st.mem[progAddr];
        end
        // Address phase
        if (takeAccess) begin
            next_st.dphase = 1'b1;
            next_st.dwrite = hwrite;
            next_st.didx = haddr[9:2];
            next_st.dmapped = (haddr[31:10] == 22'h000000) &&
                              (haddr[1:0] == 2'h0);
            if (!hwrite) begin
                next_st.rdata = regRead(next_st, haddr[9:2],
                                        next_st.dmapped);
            end
        end
        // Synchronous device reset; the array is nonvolatile
        if (!rst_n) begin
            next_st.dataReg = DATA_RESET;
            next_st.addrReg = ADDR_RESET;
            next_st.permit = 1'b0;
            next_st.wrBit = 1'b0;
            next_st.rdBit = 1'b0;
            next_st.doneFlag = 1'b0;
            next_st.unlock = STAGE_NONE;
            next_st.wstate = DEE_IDLE;
            next_st.wcount = '0;
            next_st.wAddr = ADDR_RESET;
            next_st.wData = DATA_RESET;
            next_st.dphase = 1'b0;
            next_st.dwrite = 1'b0;
            next_st.dmapped = 1'b0;
            next_st.didx = 8'h00;
            next_st.rdata = 8'h00;
            next_st.progData = 8'h00;
            if (powerOnRst) begin
                next_st.errFlag = 1'b0;
                next_st.pwrt = CNT_W'(PWRT_CYCLES);
            end else if (st.wstate == DEE_BUSY) begin
                next_st.errFlag = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        st <= next_st;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign readByte = st.rdata;
    assign hrdata = {24'h000000, readByte};
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign progData = st.progData;
    assign writeBusy = st.wrBit;
    assign programDoneFlag = st.doneFlag;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic ctrlWrite;
    logic [7:0] addrByte;
    logic [CNT_W-1:0] busyCount;

    assign ctrlWrite = st.dphase && st.dwrite && st.dmapped &&
                       st.didx == IDX_CTRL;
    assign addrByte = st.mem[st.addrReg];

    always_ff @(posedge core_clk) begin
        if (!rst_n || st.wstate == DEE_IDLE) begin
            busyCount <= '0;
        end else begin
            busyCount <= busyCount + 1'b1;
        end
    end

    property p_rd_one_cycle;
        @(posedge core_clk) disable iff (!rst_n)
        st.rdBit |=> !st.rdBit;
    endproperty
    a_rd_one_cycle: assert property (p_rd_one_cycle)
        else $error("read start bit held past one cycle");

    property p_rd_loads;
        @(posedge core_clk) disable iff (!rst_n)
        (ctrlWrite && hwdata[CTRL_RD]) |=>
            st.rdBit && st.dataReg == $past(addrByte);
    endproperty
    a_rd_loads: assert property (p_rd_loads)
        else $error("read did not load the addressed byte");

    property p_start_permit;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(st.wrBit) |-> $past(st.permit) && $past(st.pwrt) == '0;
    endproperty
    a_start_permit: assert property (p_start_permit)
        else $error("write started without permit or during power-up");

    property p_start_unlock;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(st.wrBit) |-> $past(st.unlock) == STAGE_ARMED &&
            st.mem[st.wAddr] == ERASED_BYTE;
    endproperty
    a_start_unlock: assert property (p_start_unlock)
        else $error("write started without unlock or erase");

    property p_done;
        @(posedge core_clk) disable iff (!rst_n)
        ($fell(st.wrBit) && $past(rst_n)) |->
            st.doneFlag && !st.errFlag && $past(busyCount) ==
            CNT_W'(WRITE_CYCLES - 1);
    endproperty
    a_done: assert property (p_done)
        else $error("completion flags or duration wrong");

    property p_wr_held;
        @(posedge core_clk) disable iff (!rst_n)
        (st.wrBit && st.wcount > CNT_W'(1)) |=> st.wrBit;
    endproperty
    a_wr_held: assert property (p_wr_held)
        else $error("write start bit cleared early");

    property p_ctrl_upper;
        @(posedge core_clk) disable iff (!rst_n)
        (takeAccess && !hwrite && haddr[9:2] == IDX_CTRL) |=>
            hrdata[7:4] == 4'h0;
    endproperty
    a_ctrl_upper: assert property (p_ctrl_upper)
        else $error("control upper bits not zero");

    property p_unlock_zero;
        @(posedge core_clk) disable iff (!rst_n)
        (takeAccess && !hwrite && haddr[9:2] == IDX_UNLOCK) |=>
            hrdata == 32'h00000000;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock register read nonzero");

    property p_permit_kept;
        @(posedge core_clk) disable iff (!rst_n)
        (st.permit && !ctrlWrite) |=> st.permit;
    endproperty
    a_permit_kept: assert property (p_permit_kept)
        else $error("permit cleared by hardware");

    property p_abort_err;
        @(posedge core_clk) disable iff (powerOnRst)
        (!rst_n && st.wstate == DEE_BUSY) |=>
            st.errFlag && st.addrReg == ADDR_RESET;
    endproperty
    a_abort_err: assert property (p_abort_err)
        else $error("aborted write not flagged");

    property p_addr_low;
        @(posedge core_clk) disable iff (!rst_n)
        (st.dphase && st.dwrite && st.dmapped && st.didx == IDX_ADDR) |=>
            st.addrReg == $past(hwdata[6:0]);
    endproperty
    a_addr_low: assert property (p_addr_low)
        else $error("address register not the low seven bits");

    property p_seq_break;
        @(posedge core_clk) disable iff (!rst_n)
        (st.dphase && !(st.dwrite && st.dmapped && st.didx == IDX_UNLOCK))
            |=> st.unlock == STAGE_NONE;
    endproperty
    a_seq_break: assert property (p_seq_break)
        else $error("unlock stage survived another transfer");

    property p_data_kept;
        @(posedge core_clk) disable iff (!rst_n)
        !(ctrlWrite && hwdata[CTRL_RD]) && !(st.dphase && st.dwrite &&
            st.dmapped && st.didx == IDX_DATA) |=> $stable(st.dataReg);
    endproperty
    a_data_kept: assert property (p_data_kept)
        else $error("data register changed without read or write");

    property p_done_kept;
        @(posedge core_clk) disable iff (!rst_n)
        st.doneFlag && !(st.dphase && st.dwrite && st.dmapped &&
            st.didx == IDX_FLAG && !hwdata[FLAG_DONE]) |=> st.doneFlag;
    endproperty
    a_done_kept: assert property (p_done_kept)
        else $error("write complete flag cleared by hardware");

    property p_por_timer;
        @(posedge core_clk)
        (!rst_n && powerOnRst) |=>
            st.pwrt == CNT_W'(PWRT_CYCLES) && !st.permit && !st.errFlag;
    endproperty
    a_por_timer: assert property (p_por_timer)
        else $error("power-on reset did not load the timer");

    property p_rst_clear;
        @(posedge core_clk)
        !rst_n |=> st.dataReg == DATA_RESET && st.addrReg == ADDR_RESET &&
            !st.permit && !st.wrBit && !st.doneFlag;
    endproperty
    a_rst_clear: assert property (p_rst_clear)
        else $error("reset left address, data or control bits set");

    property p_busy_bit;
        @(posedge core_clk) disable iff (!rst_n)
        st.wstate == DEE_BUSY |-> st.wrBit;
    endproperty
    a_busy_bit: assert property (p_busy_bit)
        else $error("engine busy while start bit is clear");

    property p_prot_deny;
        @(posedge core_clk) disable iff (!rst_n)
        (progRead && dataProtect) |=> progData == 8'h00;
    endproperty
    a_prot_deny: assert property (p_prot_deny)
        else $error("programmer path read the array under protection");

    c_write_done: cover property (@(posedge core_clk) disable iff (!rst_n)
        $fell(st.wrBit) && $past(rst_n));
    c_read: cover property (@(posedge core_clk) disable iff (!rst_n)
        st.rdBit);
    c_blocked: cover property (@(posedge core_clk) disable iff (!rst_n)
        ctrlWrite && hwdata[CTRL_WR] && !st.wrBit && !next_st.wrBit);
    c_abort: cover property (@(posedge core_clk)
        !rst_n && !powerOnRst && st.wstate == DEE_BUSY);
    c_protect: cover property (@(posedge core_clk) disable iff (!rst_n)
        progRead && dataProtect);

endmodule

// ---- dv/dee_access_ctrl_bench.sv ----
`timescale 1ns/1ps
module dee_access_ctrl_bench
    import dee_pkg::*;
;
    localparam int PWRT = 20;
    localparam int WCYC = 10;
    logic core_clk = 1'b0;
    logic rst_n, powerOnRst, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic dataProtect, progRead, writeBusy, programDoneFlag;
    logic [6:0] progAddr;
    logic [7:0] progData;
    logic [7:0] regs [5] = '{IDX_FLAG, IDX_DATA, IDX_ADDR, IDX_CTRL,
                             IDX_UNLOCK};
    int error_cnt = 0;
    int checks = 0;
    int n;

    always #10 core_clk = ~core_clk;

    dee_access_ctrl #(.PWRT_CYCLES(PWRT), .WRITE_CYCLES(WCYC)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .powerOnRst(powerOnRst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dataProtect(dataProtect), .progRead(progRead),
        .progAddr(progAddr), .progData(progData), .writeBusy(writeBusy),
        .programDoneFlag(programDoneFlag)
    );

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus_wr(input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= 1'b1;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge core_clk); while (hreadyout !== 1'b1);
    endtask

    task automatic bus_rd(input logic [7:0] idx, output logic [31:0] v);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= 1'b0;
        htrans <= 2'h2;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        v = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        bus_rd(idx, rd);
        chk(rd, {24'h0, exp});
        chk({31'h0, hresp}, 32'h0);
    endtask

    task automatic prog(input logic [7:0] a, input logic [7:0] d);
        bus_wr(IDX_ADDR, a);
        bus_wr(IDX_DATA, d);
        bus_wr(IDX_CTRL, 8'h04);
        bus_wr(IDX_UNLOCK, UNLOCK_FIRST);
        bus_wr(IDX_UNLOCK, UNLOCK_SECOND);
        bus_wr(IDX_CTRL, 8'h06);
    endtask

    task automatic try_bad(input logic [7:0] i0, d0, i1, d1, i2, d2, fin,
                           input logic [7:0] expc);
        bus_wr(IDX_CTRL, 8'h04);
        bus_wr(i0, d0);
        bus_wr(i1, d1);
        bus_wr(i2, d2);
        bus_wr(IDX_CTRL, fin);
        @(posedge core_clk);
        chk({31'h0, writeBusy}, 32'h0);
        rd_chk(IDX_CTRL, expc);
    endtask

    task automatic wait_idle();
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (writeBusy === 1'b1 && n < 100);
        chk({31'h0, writeBusy}, 32'h0);
    endtask

    task automatic wrap_up();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #(20 * 5000);
        error_cnt++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        powerOnRst = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WORD;
        hwdata = 32'h0;
        dataProtect = 1'b0;
        progRead = 1'b1;
        progAddr = 7'h05;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        powerOnRst <= 1'b0;
        // Start attempt while the power-up timer still runs
        try_bad(IDX_UNLOCK, 8'h00, IDX_UNLOCK, UNLOCK_FIRST, IDX_UNLOCK,
                UNLOCK_SECOND, 8'h06, 8'h04);
        bus_wr(IDX_CTRL, 8'h00);
        for (int i = 0; i < 5; i++) begin
            rd_chk(regs[i], 8'h00);
        end
        repeat (PWRT) @(posedge core_clk);
        try_bad(IDX_CTRL, 8'h00, IDX_UNLOCK, UNLOCK_FIRST, IDX_UNLOCK,
                UNLOCK_SECOND, 8'h02, 8'h00);
        // Good write with address bit 7 set, permit dropped mid-write
        prog(8'h85, 8'h3C);
        @(posedge core_clk);
        chk({31'h0, writeBusy}, 32'h1);
        @(posedge core_clk);
        chk({24'h0, progData}, {24'h0, ERASED_BYTE});
        bus_wr(IDX_CTRL, 8'h00);
        @(posedge core_clk);
        chk({31'h0, writeBusy}, 32'h1);
        wait_idle();
        chk({31'h0, programDoneFlag}, 32'h1);
        rd_chk(IDX_CTRL, 8'h00);
        rd_chk(IDX_FLAG, 8'h80);
        bus_wr(IDX_FLAG, 8'h00);
        rd_chk(IDX_FLAG, 8'h00);
        rd_chk(IDX_ADDR, 8'h05);
        bus_wr(IDX_DATA, 8'h77);
        rd_chk(IDX_DATA, 8'h77);
        bus_wr(IDX_CTRL, 8'h01);
        rd_chk(IDX_DATA, 8'h3C);
        rd_chk(IDX_CTRL, 8'h00);
        bus_wr(IDX_CTRL, 8'hF0);
        rd_chk(IDX_CTRL, 8'h00);
        // Broken unlock sequences
        try_bad(IDX_UNLOCK, UNLOCK_FIRST, IDX_FLAG, 8'h00, IDX_UNLOCK,
                UNLOCK_SECOND, 8'h06, 8'h04);
        try_bad(IDX_UNLOCK, UNLOCK_SECOND, IDX_UNLOCK, UNLOCK_FIRST,
                IDX_UNLOCK, UNLOCK_FIRST, 8'h06, 8'h04);
        try_bad(IDX_UNLOCK, UNLOCK_FIRST, IDX_UNLOCK, UNLOCK_SECOND,
                IDX_DATA, 8'h11, 8'h06, 8'h04);
        bus_wr(IDX_ADDR, 8'h05);
        bus_wr(IDX_CTRL, 8'h05);
        rd_chk(IDX_DATA, 8'h3C);
        // Timed overwrite of the same location
        prog(8'h05, 8'hA5);
        wait_idle();
        chk(n, WCYC + 1);
        bus_wr(IDX_CTRL, 8'h01);
        rd_chk(IDX_DATA, 8'hA5);
        bus_wr(IDX_FLAG, 8'h00);
        // Reset in mid-write
        prog(8'h10, 8'h99);
        rst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd_chk(IDX_CTRL, 8'h08);
        rd_chk(IDX_ADDR, 8'h00);
        rd_chk(IDX_DATA, 8'h00);
        bus_wr(IDX_CTRL, 8'h00);
        rd_chk(IDX_CTRL, 8'h00);
        // Programmer path denied, CPU path kept
        dataProtect <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({24'h0, progData}, 32'h0);
        bus_wr(IDX_ADDR, 8'h05);
        bus_wr(IDX_CTRL, 8'h01);
        rd_chk(IDX_DATA, 8'hA5);
        dataProtect <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk({24'h0, progData}, 32'hA5);
        rd_chk(8'h50, 8'h00);
        wrap_up();
    end
endmodule
